// ### verilog/prwl_pkg.sv
// prwl_pkg: constants for the pin remap write lock block
// assumes: single system clock, asynchronous active-low device reset
package prwl_pkg;
    // system configuration control: remap lock position and reset
    localparam int unsigned LOCK_BIT_POS      = 13;
    localparam logic        LOCK_RESET_VAL    = 1'b0;
    // device configuration word three: one-way option position
    localparam int unsigned ONE_WAY_BIT_POS   = 29;
    localparam logic [31:0] CFG3_UNPROGRAMMED = 32'hFFFF_FFFF;
    // mapping fields
    localparam int unsigned SEL_WIDTH         = 4;
    localparam logic [3:0]  OUT_SEL_RESET     = 4'h0;
    localparam logic [3:0]  IN_SEL_RESET      = 4'h0;
    localparam logic [3:0]  OUT_SEL_NULL      = 4'h0;
    // write session state
    typedef enum logic [1:0]
    {
        PRWL_OPEN    = 2'b00,
        PRWL_LOCKED  = 2'b01,
        PRWL_FROZEN  = 2'b10
    } prwl_state_type;
endpackage

// ### verilog/prwl_map_if.sv
// prwl_map_if: mapping write requests between lock controller and map store
// assumes: both ends on the same system clock
`timescale 1ns/1ps
interface prwl_map_if #(parameter int N = 8);
    logic           wr_en;
    logic           wr_is_out;
    logic [7:0]     wr_idx;
    logic [3:0]     wr_data;
    logic           lock;
    modport ctrl  (output wr_en, output wr_is_out, output wr_idx, output wr_data, output lock);
    modport store (input wr_en, input wr_is_out, input wr_idx, input wr_data, input lock);
endinterface

// ### verilog/prwl_map_store.sv
// prwl_map_store: input-select and output-select mapping registers
// assumes: write requests arrive from prwl_top over prwl_map_if
`timescale 1ns/1ps
module prwl_map_store #(
    parameter int N_OUT = 8,
    parameter int N_IN  = 8
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   arst_n,
    // requests
    prwl_map_if.store                   req,
    // stored fields
    output logic [N_OUT*4-1:0]          out_sel_r,
    output logic [N_IN*4-1:0]           in_sel_r
);
    // one always_ff per field; a locked write completes but stores nothing
    genvar g;
    generate
        for (g = 0; g < N_OUT; g++)
        begin : g_out
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                    out_sel_r[g*4 +: 4] <= prwl_pkg::OUT_SEL_RESET;
                else if (req.wr_en && !req.lock && req.wr_is_out && req.wr_idx == 8'(g))
                    out_sel_r[g*4 +: 4] <= req.wr_data;
            end
        end
        for (g = 0; g < N_IN; g++)
        begin : g_in
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                    in_sel_r[g*4 +: 4] <= prwl_pkg::IN_SEL_RESET;
                else if (req.wr_en && !req.lock && !req.wr_is_out && req.wr_idx == 8'(g))
                    in_sel_r[g*4 +: 4] <= req.wr_data;
            end
        end
    endgenerate
endmodule

// ### verilog/prwl_top.sv
// prwl_top: write lock for the peripheral pin remapping registers
// assumes: unlock strobe is a same-clock qualified pulse from system control;
// configuration word three is stable same-clock data after reset release
`timescale 1ns/1ps
module prwl_top #(
    parameter int N_OUT = 8,
    parameter int N_IN  = 8
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   arst_n,
    // system control
    input  wire logic                   unlock_strobe,
    input  wire logic [31:0]            device_config_word_three,
    input  wire logic                   cfg3_programmed,
    // system configuration control write
    input  wire logic                   cfg_wr,
    input  wire logic [31:0]            cfg_wdata,
    // mapping register writes
    input  wire logic                   map_wr,
    input  wire logic                   map_is_out,
    input  wire logic [7:0]             map_idx,
    input  wire logic [3:0]             map_wdata,
    // status and mapping outputs
    output logic                        remap_lock_bit,
    output logic                        frozen,
    output logic [N_OUT*4-1:0]          pin_output_select_reg,
    output logic [N_IN*4-1:0]           input_select_reg
);
    // refuse map counts that the 8-bit index cannot reach, at elaboration
    if (N_OUT < 1 || N_OUT > 256 || N_IN < 1 || N_IN > 256)
    begin : g_bad_counts
        $error("prwl_top: map counts must be 1..256");
    end

    logic                    unlock_open_r;
    logic                    one_way_r;
    logic                    cfg_seen_r;
    prwl_pkg::prwl_state_type state_r;
    prwl_pkg::prwl_state_type state_nxt;
    logic                    lock_wr_ok;
    logic                    want_lock;

    prwl_map_if #(.N(N_OUT)) map_bus ();

    // unlock window lasts exactly the cycle after the strobe
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            unlock_open_r <= 1'b0;
        else
            unlock_open_r <= unlock_strobe;
    end

    // catch the one-way option after reset release; unprogrammed reads as set
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            one_way_r  <= 1'b1;  // safe default until the word is seen
            cfg_seen_r <= 1'b0;
        end
        else if (!cfg_seen_r)
        begin
            cfg_seen_r <= 1'b1;
            one_way_r  <= cfg3_programmed
                ? device_config_word_three[prwl_pkg::ONE_WAY_BIT_POS]
                : prwl_pkg::CFG3_UNPROGRAMMED[prwl_pkg::ONE_WAY_BIT_POS];
        end
    end

    // lock write qualifies only inside the unlock window
    assign lock_wr_ok = cfg_wr && unlock_open_r;
    assign want_lock  = cfg_wdata[prwl_pkg::LOCK_BIT_POS];

    // lock state: frozen has no exit but reset
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            prwl_pkg::PRWL_OPEN:
                if (lock_wr_ok && want_lock)
                    state_nxt = one_way_r ? prwl_pkg::PRWL_FROZEN
                                          : prwl_pkg::PRWL_LOCKED;
            prwl_pkg::PRWL_LOCKED:
                if (lock_wr_ok && !want_lock)
                    state_nxt = prwl_pkg::PRWL_OPEN;
            prwl_pkg::PRWL_FROZEN:
                state_nxt = prwl_pkg::PRWL_FROZEN;
            default:
                state_nxt = prwl_pkg::PRWL_FROZEN;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            state_r <= prwl_pkg::PRWL_OPEN;
        else
            state_r <= state_nxt;
    end

    // registered status outputs track the next state
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            remap_lock_bit <= prwl_pkg::LOCK_RESET_VAL;
            frozen         <= 1'b0;
        end
        else
        begin
            remap_lock_bit <= (state_nxt != prwl_pkg::PRWL_OPEN);
            frozen         <= (state_nxt == prwl_pkg::PRWL_FROZEN);
        end
    end

    // mapping writes gated by the current lock value
    assign map_bus.wr_en     = map_wr;
    assign map_bus.wr_is_out = map_is_out;
    assign map_bus.wr_idx    = map_idx;
    assign map_bus.wr_data   = map_wdata;
    assign map_bus.lock      = remap_lock_bit;

    prwl_map_store #(
        .N_OUT (N_OUT),
        .N_IN  (N_IN)
    ) u_store (
        .clock     (clock),
        .arst_n    (arst_n),
        .req       (map_bus),
        .out_sel_r (pin_output_select_reg),
        .in_sel_r  (input_select_reg)
    );
endmodule

// ### dv/prwl_top_assertions.sv
// prwl_top_assertions: lock and mapping checks on the top ports
// assumes: bound to prwl_top, one clock, asynchronous active-low reset
`timescale 1ns/1ps
module prwl_top_assertions #(
    parameter int N_OUT = 8,
    parameter int N_IN  = 8
) (
    // clock and reset
    input wire logic               clock,
    input wire logic               arst_n,
    // controls
    input wire logic               unlock_strobe,
    input wire logic [31:0]        device_config_word_three,
    input wire logic               cfg3_programmed,
    input wire logic               cfg_wr,
    input wire logic [31:0]        cfg_wdata,
    // status and fields
    input wire logic               remap_lock_bit,
    input wire logic               frozen,
    input wire logic [N_OUT*4-1:0] pin_output_select_reg,
    input wire logic [N_IN*4-1:0]  input_select_reg
);
    // all checks share the one clock; reset masks them
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    lock_needs_key_a: assert property ($changed(remap_lock_bit) |->
        $past(cfg_wr) && $past(unlock_strobe, 2)) else $error("lock moved without key");
    lock_rise_a: assert property ($rose(remap_lock_bit) |->
        $past(cfg_wdata[13])) else $error("lock set without bit 13");
    lock_fall_a: assert property ($fell(remap_lock_bit) |->
        !$past(cfg_wdata[13]) && !$past(frozen)) else $error("bad lock clear");
    frozen_hold_a: assert property (frozen |=> frozen)
        else $error("frozen dropped without reset");
    frozen_locked_a: assert property (frozen |-> remap_lock_bit)
        else $error("frozen while unlocked");
    frozen_cause_a: assert property ($rose(frozen) |-> $rose(remap_lock_bit))
        else $error("frozen without lock set");
    one_way_a: assert property ($rose(remap_lock_bit) |-> frozen ==
        (!cfg3_programmed || device_config_word_three[29])) else $error("one-way wrong");
    locked_map_a: assert property (remap_lock_bit |=> $stable(pin_output_select_reg)
        && $stable(input_select_reg)) else $error("map changed while locked");
    // main scenarios reached
    cover property ($rose(frozen));
    cover property ($fell(remap_lock_bit));
    cover property ($changed(input_select_reg));
endmodule
bind prwl_top prwl_top_assertions #(.N_OUT(N_OUT), .N_IN(N_IN)) u_chk (.clock(clock),
    .arst_n(arst_n), .unlock_strobe(unlock_strobe), .cfg3_programmed(cfg3_programmed),
    .device_config_word_three(device_config_word_three), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .remap_lock_bit(remap_lock_bit), .frozen(frozen),
    .pin_output_select_reg(pin_output_select_reg), .input_select_reg(input_select_reg));

// ### dv/tb_pin_remap_write_lock.sv
// tb_pin_remap_write_lock: directed checks of the remap write lock
// assumes: prwl_top with eight output and eight input select fields
`timescale 1ns/1ps
module tb_pin_remap_write_lock;
    logic        clock = 0, arst_n = 0, unlock_strobe = 0, cfg_wr = 0, map_wr = 0;
    logic        cfg3_programmed = 1, map_is_out = 0, remap_lock_bit, frozen;
    logic [31:0] device_config_word_three = 0, cfg_wdata = 0;
    logic [7:0]  map_idx = 0;
    logic [3:0]  map_wdata = 0;
    logic [31:0] pin_output_select_reg, input_select_reg;
    int          n_fail = 0, check_count = 0, cyc = 0;
    prwl_top #(.N_OUT(8), .N_IN(8)) dut (.clock(clock), .arst_n(arst_n),
        .unlock_strobe(unlock_strobe), .device_config_word_three(device_config_word_three),
        .cfg3_programmed(cfg3_programmed), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .map_wr(map_wr), .map_is_out(map_is_out), .map_idx(map_idx), .map_wdata(map_wdata),
        .remap_lock_bit(remap_lock_bit), .frozen(frozen),
        .pin_output_select_reg(pin_output_select_reg), .input_select_reg(input_select_reg));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    // s = strobe the cycle before the lock write; config word sampled after release
    task automatic key(input logic s, input logic v);
        @(negedge clock);
        unlock_strobe = s;
        @(negedge clock);
        unlock_strobe = 0;
        cfg_wr = 1;
        cfg_wdata = {18'h0, v, 13'h0};
        @(negedge clock);
        cfg_wr = 0;
    endtask
    // leaves map_wr high so writes can run back to back
    task automatic mwr(input logic o, input logic [7:0] i, input logic [3:0] d);
        @(negedge clock);
        {map_wr, map_is_out, map_idx, map_wdata} = {1'b1, o, i, d};
    endtask
    // one idle edge first, so the last lock change is sampled before reset masks checks
    task automatic rst(input logic prog, input logic [31:0] word);
        @(negedge clock);
        arst_n = 0;
        {cfg3_programmed, device_config_word_three} = {prog, word};
        repeat (3) @(negedge clock);
        arst_n = 1;
        repeat (2) @(negedge clock);
    endtask
    task automatic t_open();
        rst(1, 32'h0000_0000);
        chk("lock", 0, remap_lock_bit);
        chk("out", 0, pin_output_select_reg);
        mwr(1, 0, 4'h5);
        mwr(0, 7, 4'hA);
        mwr(1, 8, 4'hF);
        @(negedge clock);
        map_wr = 0;
        chk("out", 32'h0000_0005, pin_output_select_reg);
        chk("in", 32'hA000_0000, input_select_reg);
    endtask
    task automatic t_key();
        key(0, 1);
        chk("lock", 0, remap_lock_bit);
        key(1, 1);
        chk("lock", 1, remap_lock_bit);
        chk("frozen", 0, frozen);
        mwr(1, 0, 4'h3);
        @(negedge clock);
        map_wr = 0;
        chk("out", 32'h0000_0005, pin_output_select_reg);
        key(1, 0);
        chk("lock", 0, remap_lock_bit);
    endtask
    task automatic t_one_way(input logic prog, input logic [31:0] word);
        rst(prog, word);
        key(1, 1);
        chk("frozen", 1, frozen);
        key(1, 0);
        chk("lock", 1, remap_lock_bit);
        mwr(0, 2, 4'h9);
        @(negedge clock);
        map_wr = 0;
        chk("in", 0, input_select_reg);
        rst(1, 32'h0000_0000);
        chk("lock", 0, remap_lock_bit);
        chk("frozen", 0, frozen);
        mwr(1, 1, 4'h6);
        @(negedge clock);
        map_wr = 0;
        chk("out", 32'h0000_0060, pin_output_select_reg);
    endtask
    task automatic finish_test();
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial forever #10 clock = ~clock;
    // whole run is under 200 cycles; ceiling cuts a hang
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            finish_test();
        end
    end
    initial
    begin
        t_open();
        t_key();
        t_one_way(0, 32'h0000_0000);
        t_one_way(1, 32'h2000_0000);
        finish_test();
    end
endmodule
